// >>> src/cpu_sideband_control.sv
// Processor sideband control: numeric error ignore, soft init, local interrupts, atomic lock
//
// Contract
// [RQ1] With ignore asserted, a pending FP error is disregarded and noncontrol FP instructions run on.
// [RQ2] With ignore deasserted, a noncontrol FP instruction faults when an earlier one left an error pending.
// [RQ3] When the native numeric-error bit of control register zero is set, the ignore input has no effect.
// [RQ4] Outside logic may change ignore at any time but must have it valid by target ready of the I/O write.
// [RQ5] Soft init resets the integer registers and leaves caches and FP registers alone.
// [RQ6] After soft init, execution restarts at the reset vector chosen at power-on configuration.
// [RQ7] Snoops are still serviced while soft init is held asserted.
// [RQ8] Soft init is taken as an asynchronous input with no timing relation to the bus clock.
// [RQ9] Soft init sampled active at reset release starts the built-in self-test.
// [RQ10] With the local interrupt controller disabled, input zero acts as the maskable interrupt line.
// [RQ11] With the local interrupt controller disabled, input one acts as the nonmaskable interrupt line.
// [RQ12] Both local interrupt inputs are taken asynchronously in either role.
// [RQ13] After reset the local interrupt controller is enabled, so the inputs act as local interrupt pins.
// [RQ14] The atomic-lock output is held from the start of the first to the end of the last locked transaction.
// [RQ15] A priority bus agent waits for lock to drop before taking the bus.
// [RQ16] Each asynchronous input passes a two-stage synchroniser before any logic reads it.
`timescale 1ns/1ns
module cpu_sideband_control
  import sideband_pkg::*;
#(
  parameter int VEC_W = VECTOR_WIDTH
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // Asynchronous sideband pins
  input  wire logic                        ignore_numeric_error_n,
  input  wire logic                        soft_init_n,
  input  wire logic [1:0]                  local_irq_pins,
  // Core configuration
  input  wire logic                        native_numeric_error_bit,
  input  wire logic                        lic_disable_req,
  input  wire logic                        lic_enable_req,
  input  wire logic [VEC_W-1:0]            reset_vector_strap,
  // Floating-point side
  input  wire sideband_pkg::fp_status_type fp_status,
  // Locked sequence from the bus unit
  input  wire logic                        locked_txn_start,
  input  wire logic                        locked_txn_last_end,
  // Snoop requests
  input  wire logic                        snoop_req,
  // Outputs
  output logic                             fp_exception,
  output logic                             int_regs_reset,
  output logic                             restart_valid,
  output logic [VEC_W-1:0]                 restart_vector,
  output logic                             builtin_self_test_start,
  output logic                             snoop_ack,
  output logic                             lic_enabled,
  output sideband_pkg::irq_route_type      irq_route,
  output logic                             lock_out_n,
  output logic                             lock_out_oe
);

  // ********************************************************************
  // Input synchronisation
  // ********************************************************************
  async_in_type raw_in;
  async_in_type sync_in;
  logic [$bits(async_in_type)-1:0] sync_bits;

  assign raw_in = '{ignore_ne: ~ignore_numeric_error_n, soft_init: ~soft_init_n,
                    irq_zero: local_irq_pins[0], irq_one: local_irq_pins[1]};

  // Pins are asynchronous; nothing reads them before the second stage
  sync_two_stage #(
    .WIDTH ($bits(async_in_type))
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (raw_in),         // [RQ16] [RQ8] [RQ12]
    .sync_out (sync_bits)
  );

  assign sync_in = async_in_type'(sync_bits);

  // ********************************************************************
  // Numeric error handling
  // ********************************************************************
  logic fp_exc_reg;
  logic fp_exc_next;
  logic ignore_effective;

  // Ignore only counts while the native bit is clear
  assign ignore_effective = sync_in.ignore_ne & ~native_numeric_error_bit; // [RQ3]

  always_comb begin
    fp_exc_next = 1'b0;
    if (fp_status.fp_noncontrol_issue && fp_status.fp_error_pending && !ignore_effective) begin
      fp_exc_next = 1'b1; // [RQ2]
    end
    // Ignored error: no exception, instruction proceeds [RQ1]
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fp_exc_reg <= 1'b0;
    end else begin
      fp_exc_reg <= fp_exc_next;
    end
  end

  assign fp_exception = fp_exc_reg;

  // ********************************************************************
  // Soft init and self-test sequencing
  // ********************************************************************
  init_state_type   init_state_reg;
  init_state_type   init_state_next;
  logic             int_rst_reg;
  logic             int_rst_next;
  logic             restart_reg;
  logic             restart_next;
  logic [VEC_W-1:0] vector_reg;
  logic [VEC_W-1:0] vector_next;
  logic             captured_reg;
  logic             captured_next;
  logic             builtin_self_test_reg;
  logic             builtin_self_test_next;
  logic             snoop_ack_reg;

  // The strap vector and the self-test request are caught on the first
  // clocks after release, never by the asynchronous reset itself. The
  // synchroniser adds its latency, so the init level seen two edges
  // after release is the one that stood at the release.
  logic [1:0] release_cnt_reg;
  logic [1:0] release_cnt_next;

  always_comb begin
    init_state_next  = init_state_reg;
    int_rst_next     = 1'b0;
    restart_next     = 1'b0;
    vector_next      = vector_reg;
    captured_next    = captured_reg;
    builtin_self_test_next        = 1'b0;
    release_cnt_next = release_cnt_reg;
    if (!captured_reg) begin
      if (release_cnt_reg == 2'h2) begin
        captured_next = 1'b1;
        vector_next   = reset_vector_strap;
        if (sync_in.soft_init) begin
          builtin_self_test_next       = 1'b1; // [RQ9]
          init_state_next = INIT_BUILTIN_SELF_TEST;
        end
      end else begin
        release_cnt_next = release_cnt_reg + 2'h1;
      end
    end else begin
      case (init_state_reg)
        INIT_RUN: begin
          if (sync_in.soft_init) begin
            init_state_next = INIT_RESET;
            int_rst_next    = 1'b1; // [RQ5]
          end
        end
        INIT_RESET: begin
          int_rst_next = 1'b1;
          if (!sync_in.soft_init) begin
            init_state_next = INIT_RUN;
            int_rst_next    = 1'b0;
            restart_next    = 1'b1; // [RQ6]
          end
        end
        INIT_BUILTIN_SELF_TEST: begin
          // Self-test requested at release; wait for init to drop
          if (!sync_in.soft_init) begin
            init_state_next = INIT_RUN;
            restart_next    = 1'b1;
          end
        end
        default: init_state_next = INIT_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_state_reg  <= INIT_RUN;
      int_rst_reg     <= 1'b0;
      restart_reg     <= 1'b0;
      vector_reg      <= VEC_W'(VECTOR_DEFAULT);
      captured_reg    <= 1'b0;
      builtin_self_test_reg        <= 1'b0;
      release_cnt_reg <= 2'h0;
      snoop_ack_reg   <= 1'b0;
    end else begin
      init_state_reg  <= init_state_next;
      int_rst_reg     <= int_rst_next;
      restart_reg     <= restart_next;
      vector_reg      <= vector_next;
      captured_reg    <= captured_next;
      builtin_self_test_reg        <= builtin_self_test_next;
      release_cnt_reg <= release_cnt_next;
      // Snoops answered regardless of init state
      snoop_ack_reg   <= snoop_req; // [RQ7]
    end
  end

  // Only integer state is reset; caches and FP registers see no signal [RQ5]
  assign int_regs_reset = int_rst_reg;
  assign restart_valid  = restart_reg;
  assign restart_vector = vector_reg;
  assign builtin_self_test_start     = builtin_self_test_reg;
  assign snoop_ack      = snoop_ack_reg;

  // ********************************************************************
  // Local interrupt routing
  // ********************************************************************
  logic          lic_en_reg;
  logic          lic_en_next;
  irq_route_type route_reg;
  irq_route_type route_next;

  always_comb begin
    lic_en_next = lic_en_reg;
    if (lic_disable_req) begin
      lic_en_next = 1'b0;
    end else if (lic_enable_req) begin
      lic_en_next = 1'b1;
    end
    route_next = '0;
    if (lic_en_reg) begin
      route_next.local_irq_zero = sync_in.irq_zero;
      route_next.local_irq_one  = sync_in.irq_one;
    end else begin
      route_next.maskable_irq    = sync_in.irq_zero; // [RQ10]
      route_next.nonmaskable_irq = sync_in.irq_one;  // [RQ11]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lic_en_reg <= LIC_ENABLE_RESET; // [RQ13]
      route_reg  <= '0;
    end else begin
      lic_en_reg <= lic_en_next;
      route_reg  <= route_next;
    end
  end

  assign lic_enabled = lic_en_reg;
  assign irq_route   = route_reg;

  // ********************************************************************
  // Atomic lock
  // ********************************************************************
  lock_state_type lock_state_reg;
  lock_state_type lock_state_next;

  always_comb begin
    lock_state_next = lock_state_reg;
    case (lock_state_reg)
      LOCK_IDLE: begin
        if (locked_txn_start) begin
          lock_state_next = LOCK_HELD; // [RQ14]
        end
      end
      LOCK_HELD: begin
        if (locked_txn_last_end) begin
          lock_state_next = LOCK_LAST;
        end
      end
      LOCK_LAST: lock_state_next = LOCK_IDLE;
      default:   lock_state_next = LOCK_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_state_reg <= LOCK_IDLE;
    end else begin
      lock_state_reg <= lock_state_next;
    end
  end

  // Held through the cycle in which the last transaction ends; a priority
  // agent sees the release one cycle later [RQ15]
  assign lock_out_n  = ~(lock_state_reg == LOCK_HELD); // [RQ14]
  assign lock_out_oe = (lock_state_reg == LOCK_HELD);

  // ********************************************************************
  // Assertions
  // ********************************************************************
  fp_ignore_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ1]
    (fp_status.fp_noncontrol_issue && fp_status.fp_error_pending && ignore_effective) |=> !fp_exception)
    else $error("exception raised while error ignored");

  fp_raise_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ2]
    (fp_status.fp_noncontrol_issue && fp_status.fp_error_pending && !ignore_effective) |=> fp_exception)
    else $error("pending error did not raise exception");

  ne_override_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ3]
    (native_numeric_error_bit && fp_status.fp_noncontrol_issue && fp_status.fp_error_pending) |=> fp_exception)
    else $error("ignore input honoured with native bit set");

  init_reset_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ5]
    (init_state_reg == INIT_RESET) |-> int_regs_reset || restart_valid || !sync_in.soft_init)
    else $error("integer reset dropped during init");

  restart_vec_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ6]
    restart_valid |-> restart_vector == $past(restart_vector))
    else $error("restart vector changed at restart");

  snoop_during_init_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ7]
    snoop_req |=> snoop_ack)
    else $error("snoop not answered");

  legacy_route_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ10] [RQ11]
    (!lic_en_reg && !lic_disable_req && !lic_enable_req) ##1 !lic_en_reg |->
      irq_route.maskable_irq == $past(sync_in.irq_zero) && irq_route.nonmaskable_irq == $past(sync_in.irq_one))
    else $error("legacy interrupt routing wrong");

  sync_delay_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ16]
    sync_in.irq_zero == $past(raw_in.irq_zero, 2) || !$past(reset_n, 2))
    else $error("synchroniser depth wrong");

  lock_take_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ14]
    (lock_state_reg == LOCK_IDLE && locked_txn_start) |=> !lock_out_n && lock_out_oe)
    else $error("lock not taken at first transaction");

  lock_span_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ14]
    (lock_state_reg == LOCK_HELD && !locked_txn_last_end) |=> !lock_out_n)
    else $error("lock dropped before last transaction ended");

  lock_drop_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ14]
    (lock_state_reg == LOCK_HELD && locked_txn_last_end) |=> lock_out_n)
    else $error("lock kept after last transaction ended");

endmodule

// >>> src/sideband_pkg.sv
// Package: shared types and constants for the processor sideband control pins
package sideband_pkg;

  // Synchroniser depth for asynchronous pins
  localparam int SYNC_STAGES = 2;

  // Reset value of the local interrupt controller enable
  localparam logic LIC_ENABLE_RESET = 1'b1;

  // Reset vector width and a plain default; the real value is strapped at power-on
  localparam int          VECTOR_WIDTH   = 32;
  localparam logic [31:0] VECTOR_DEFAULT = 32'h0000_0000;

  // Synchronised asynchronous inputs, all active high inside the block
  typedef struct packed {
    logic ignore_ne;
    logic soft_init;
    logic irq_zero;
    logic irq_one;
  } async_in_type;

  // Floating-point execution side of the core
  typedef struct packed {
    logic fp_error_pending;
    logic fp_noncontrol_issue;
  } fp_status_type;

  // Legacy / local interrupt routing outputs
  typedef struct packed {
    logic maskable_irq;
    logic nonmaskable_irq;
    logic local_irq_zero;
    logic local_irq_one;
  } irq_route_type;

  // Lock tracking states
  typedef enum logic [2:0] {
    LOCK_IDLE = 3'b001,
    LOCK_HELD = 3'b010,
    LOCK_LAST = 3'b100
  } lock_state_type;

  // Init sequencer states
  typedef enum logic [2:0] {
    INIT_RUN   = 3'b001,
    INIT_RESET = 3'b010,
    INIT_BUILTIN_SELF_TEST  = 3'b100
  } init_state_type;

endpackage

// >>> src/sync_two_stage.sv
// Two flip-flop synchroniser, one per bit
`timescale 1ns/1ns
module sync_two_stage #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] first_reg;
  logic [WIDTH-1:0] second_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_reg  <= '0;
      second_reg <= '0;
    end else begin
      first_reg  <= async_in;
      second_reg <= first_reg;
    end
  end

  assign sync_out = second_reg;

endmodule

// >>> verification/chipset_model.sv
// Partner model: chipset side of the sideband pins plus a priority bus agent
`timescale 1ns/1ns
module chipset_model (
  // Clock
  input  wire logic       clk,
  // Lock pin as driven by the processor
  input  wire logic       lock_out_n,
  input  wire logic       lock_out_oe,
  // Sideband pins driven by the chipset
  output logic            ignore_numeric_error_n,
  output logic            soft_init_n,
  output logic [1:0]      local_irq_pins,
  // Priority agent
  input  wire logic       prio_want,
  output logic            prio_owner
);
  // ****************************************
  // Pin drivers
  // ****************************************
  logic lock_wire;
  logic target_ready_n;
  // Termination pulls the lock line high whenever nobody drives it
  assign lock_wire = lock_out_oe ? lock_out_n : 1'b1;
  initial begin
    ignore_numeric_error_n = 1'b1;
    soft_init_n            = 1'b1;
    local_irq_pins         = 2'h0;
    target_ready_n         = 1'b1;
    prio_owner             = 1'b0;
  end
  // Ignore is settled well before target ready of the I/O write completes
  task automatic io_write_ignore(input logic ign_n);
    ignore_numeric_error_n = ign_n;
    repeat (3) @(posedge clk);
    #1 target_ready_n = 1'b0;
    @(posedge clk);
    #1 target_ready_n = 1'b1;
  endtask
  // Held low across reset release it requests the self-test
  task automatic set_init(input logic init_n);
    soft_init_n = init_n;
  endtask
  task automatic set_irq(input logic [1:0] pins);
    local_irq_pins = pins;
  endtask
  // The agent takes the bus only once it sees lock released, keeping the sequence atomic
  always @(posedge clk) begin
    prio_owner <= prio_want && (prio_owner || lock_wire);
  end
endmodule

// >>> verification/cpu_sideband_control_bench.sv
// Testbench for the processor sideband control pins
`timescale 1ns/1ns
module cpu_sideband_control_bench;
  import sideband_pkg::*;
  logic          clk;
  logic          reset_n;
  logic          ne_bit;
  logic          lic_dis;
  logic          lic_en;
  logic          lk_start;
  logic          lk_end;
  logic          snoop_req;
  logic          prio_want;
  logic          prio_owner;
  logic          ign_n;
  logic          init_n;
  logic [1:0]    irq_pins;
  logic [31:0]   strap;
  logic [31:0]   rvec;
  fp_status_type fp_st;
  irq_route_type route;
  logic          fp_exc;
  logic          regs_rst;
  logic          rst_valid;
  logic          builtin_self_test;
  logic          snoop_ack;
  logic          lic_on;
  logic          lock_n;
  logic          lock_oe;
  int            errors;
  int            num_checks;

  cpu_sideband_control cpu_sideband_control_inst (
    .clk(clk), .reset_n(reset_n), .ignore_numeric_error_n(ign_n), .soft_init_n(init_n),
    .local_irq_pins(irq_pins), .native_numeric_error_bit(ne_bit), .lic_disable_req(lic_dis),
    .lic_enable_req(lic_en), .reset_vector_strap(strap), .fp_status(fp_st),
    .locked_txn_start(lk_start), .locked_txn_last_end(lk_end), .snoop_req(snoop_req),
    .fp_exception(fp_exc), .int_regs_reset(regs_rst), .restart_valid(rst_valid),
    .restart_vector(rvec), .builtin_self_test_start(builtin_self_test), .snoop_ack(snoop_ack), .lic_enabled(lic_on),
    .irq_route(route), .lock_out_n(lock_n), .lock_out_oe(lock_oe));
  chipset_model chipset_model_inst (
    .clk(clk), .lock_out_n(lock_n), .lock_out_oe(lock_oe), .ignore_numeric_error_n(ign_n),
    .soft_init_n(init_n), .local_irq_pins(irq_pins), .prio_want(prio_want), .prio_owner(prio_owner));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // A wait that runs out of cycles ends the run at once
  task automatic wait_for(input string name, ref logic sig, input int bound);
    int i;
    for (i = 0; i < bound && sig !== 1'b1; i++) tick();
    check(name, sig, 1'b1);
    if (sig !== 1'b1) summarize();
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    int   k;
    logic seen_b;
    errors     = 0;
    num_checks = 0;
    reset_n    = 1'b0;
    ne_bit     = 1'b0;
    lic_dis    = 1'b0;
    lic_en     = 1'b0;
    lk_start   = 1'b0;
    lk_end     = 1'b0;
    snoop_req  = 1'b0;
    prio_want  = 1'b0;
    strap      = 32'h0012_3450;
    fp_st      = '0;
    seen_b     = 1'b0;
    tick(4);
    reset_n = 1'b1;
    for (k = 0; k < 8; k++) begin
      tick();
      seen_b |= builtin_self_test;
    end
    check("builtin_self_test_idle", seen_b, 1'b0);
    check("lic_enabled", lic_on, 1'b1);
    // Every combination of native bit, ignore pin and pending error
    for (k = 0; k < 8; k++) begin
      ne_bit = k[2];
      chipset_model_inst.io_write_ignore(~k[1]);
      tick(3);
      fp_st = '{fp_error_pending: k[0], fp_noncontrol_issue: 1'b1};
      tick();
      check("fp_exception", fp_exc, k[0] & (k[2] | ~k[1]));
      fp_st = '0;
    end
    chipset_model_inst.set_irq(2'h3);
    tick(3);
    check("local_irq_zero", route.local_irq_zero, 1'b1);
    check("local_irq_one", route.local_irq_one, 1'b1);
    check("maskable_irq", route.maskable_irq, 1'b0);
    lic_dis = 1'b1;
    tick();
    lic_dis = 1'b0;
    check("lic_enabled", lic_on, 1'b0);
    for (k = 1; k < 3; k++) begin
      chipset_model_inst.set_irq(k[1:0]);
      tick(3);
      check("maskable_irq", route.maskable_irq, k[0]);
      check("nonmaskable_irq", route.nonmaskable_irq, k[1]);
    end
    // Re-enable, then a disable and an enable together: disable wins
    lic_en = 1'b1;
    tick();
    lic_en = 1'b0;
    check("lic_enabled", lic_on, 1'b1);
    lic_dis = 1'b1;
    lic_en  = 1'b1;
    tick();
    lic_dis = 1'b0;
    lic_en  = 1'b0;
    check("lic_enabled", lic_on, 1'b0);
    chipset_model_inst.set_init(1'b0);
    tick(4);
    check("int_regs_reset", regs_rst, 1'b1);
    snoop_req = 1'b1;
    tick();
    snoop_req = 1'b0;
    check("snoop_ack", snoop_ack, 1'b1);
    chipset_model_inst.set_init(1'b1);
    wait_for("restart_valid", rst_valid, 8);
    check("restart_vector", rvec, strap);
    tick(2);
    check("int_regs_reset", regs_rst, 1'b0);
    lk_start = 1'b1;
    tick();
    lk_start  = 1'b0;
    prio_want = 1'b1;
    check("lock_out_oe", lock_oe, 1'b1);
    tick(5);
    check("lock_out_n", lock_n, 1'b0);
    check("prio_owner", prio_owner, 1'b0);
    lk_end = 1'b1;
    tick();
    lk_end = 1'b0;
    wait_for("lock_released", lock_n, 2);
    wait_for("prio_owner", prio_owner, 4);
    // Second reset with the self-test requested; controller comes back enabled
    reset_n = 1'b0;
    chipset_model_inst.set_init(1'b0);
    tick(4);
    reset_n = 1'b1;
    check("lic_enabled", lic_on, 1'b1);
    wait_for("builtin_self_test_start", builtin_self_test, 8);
    chipset_model_inst.set_init(1'b1);
    tick(8);
    summarize();
  end
endmodule
